// ---- pcsmc_pkg.sv ----
// Behaviour
// - loopback bit puts the serial transceiver in internal loopback
// - ten-bit variant drives loopback bit onto the external wrap output
// - control bit 13, speed lsb, always reads zero
// - control bit 6, speed msb, always reads one
// - control bits 12,9,5 plain storage; status 5 reads one, 3 zero
// - power down sets transceiver low power; only a core reset clears it
// - ten-bit variant: power down bit is storage only
// - isolate, set after reset, disconnects phy logic from gmii
// - duplex bit reads one, collision test reads zero, writes ignored
// - control bits 4:0 read zero and ignore writes
// - status bit 8 reads one, extended status present
// - status bit 7 reads one, writes ignored
// - status bit 6 reads one, preamble may be omitted by manager
// - status bit 4, remote fault, reads zero
// - status bit 2 latches low on link drop until status read
// - a status read reloads latched link bit with present link state
// - link is one while receive synchronisation is held and until the link timer runs out after its loss
// - link drop may wait one full link timer after sync loss
// - status bit 0, extended capability, reads zero
// - unimplemented addresses read zero and are read only
package pcsmc_pkg;
  localparam logic [4:0]  ADDR_CTRL    = 5'h00;
  localparam logic [4:0]  ADDR_STAT    = 5'h01;
  localparam int          CB_RESET     = 15;
  localparam int          CB_LOOP      = 14;
  localparam int          CB_SPD_LSB   = 13;
  localparam int          CB_AN_EN     = 12;
  localparam int          CB_PWR       = 11;
  localparam int          CB_ISO       = 10;
  localparam int          CB_AN_RST    = 9;
  localparam int          CB_DUPLEX    = 8;
  localparam int          CB_COLTEST   = 7;
  localparam int          CB_SPD_MSB   = 6;
  localparam int          CB_UNIDIR    = 5;
  localparam int          SB_EXT_STAT  = 8;
  localparam int          SB_UNIDIR    = 7;
  localparam int          SB_PRE_SUPP  = 6;
  localparam int          SB_AN_DONE   = 5;
  localparam int          SB_LINK      = 2;
  localparam logic        RST_AN_EN    = 1'b1;
  localparam logic        RST_ISO      = 1'b1;
  localparam logic        RST_LOOP     = 1'b0;
  localparam logic        RST_PWR      = 1'b0;
  localparam logic        RST_AN_RST   = 1'b0;
  localparam logic        RST_UNIDIR   = 1'b0;
  localparam logic        RST_LINK     = 1'b0;
  localparam logic [15:0] STAT_FIXED   = 16'h01e0;
  localparam logic [15:0] CTRL_FIXED   = 16'h0140;
  localparam int          CLK_NS       = 50;
  localparam int          LINK_TIMER_NS = 10000000;
  localparam int          LINK_TIMER_CYC = LINK_TIMER_NS / CLK_NS;
  localparam int          LT_W         = 18;
endpackage : pcsmc_pkg

// ---- pcsmc_regs.sv ----
`timescale 1ns/1ps
module pcsmc_regs #(
  parameter bit TBI_VARIANT    = 1'b0,
  parameter int LINK_TIMER_CYC = pcsmc_pkg::LINK_TIMER_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // register access port from the management frame engine
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // receive synchronisation from the coding sublayer
  input  wire logic        rx_sync,
  // controls to the datapath and transceiver
  output logic             core_reset,
  output logic             serdes_loopback,
  output logic             ewrap,
  output logic             serdes_power_down,
  output logic             gmii_isolate,
  output logic             link_ok
);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] t);
    hit = (a == t);
  endfunction : hit

  // control storage
  logic             rst_bit_q;
  logic             rst_bit_d;
  logic             loop_q;
  logic             loop_d;
  logic             an_en_q;
  logic             an_en_d;
  logic             pwr_q;
  logic             pwr_d;
  logic             iso_q;
  logic             iso_d;
  logic             an_rst_q;
  logic             an_rst_d;
  logic             unidir_q;
  logic             unidir_d;
  // link tracking
  logic             link_q;
  logic             link_d;
  logic             latch_q;
  logic             latch_d;
  logic [pcsmc_pkg::LT_W-1:0] lt_cnt_q;
  logic [pcsmc_pkg::LT_W-1:0] lt_cnt_d;
  // read port and outputs
  logic [15:0]      rdata_q;
  logic [15:0]      rdata_d;
  logic             rvalid_q;
  logic             core_reset_q;
  logic             sl_q;
  logic             ewrap_q;
  logic             spd_q;
  logic             iso_out_q;

  wire        wr_ctrl  = reg_wr & hit(reg_addr, pcsmc_pkg::ADDR_CTRL);
  wire        rd_ctrl  = reg_rd & hit(reg_addr, pcsmc_pkg::ADDR_CTRL);
  wire        rd_stat  = reg_rd & hit(reg_addr, pcsmc_pkg::ADDR_STAT);
  wire        lt_done  = (lt_cnt_q ==
                          pcsmc_pkg::LT_W'(LINK_TIMER_CYC - 1));

  // control word as read back; fixed bits come from the constant
  wire [15:0] ctrl_rd  = pcsmc_pkg::CTRL_FIXED
                       | ({15'h0000, rst_bit_q} << pcsmc_pkg::CB_RESET)
                       | ({15'h0000, loop_q}    << pcsmc_pkg::CB_LOOP)
                       | ({15'h0000, an_en_q}   << pcsmc_pkg::CB_AN_EN)
                       | ({15'h0000, pwr_q}     << pcsmc_pkg::CB_PWR)
                       | ({15'h0000, iso_q}     << pcsmc_pkg::CB_ISO)
                       | ({15'h0000, an_rst_q}  << pcsmc_pkg::CB_AN_RST)
                       | ({15'h0000, unidir_q}  << pcsmc_pkg::CB_UNIDIR);
  // bits 4:0 never set above

  // status word: abilities fixed, link bit latched
  // bits 15:9, 4, 3, 1 and 0 never set
  wire [15:0] stat_rd  = pcsmc_pkg::STAT_FIXED
                       | ({15'h0000, latch_q} << pcsmc_pkg::SB_LINK);

  assign rdata_d = rd_ctrl ? ctrl_rd :
                   rd_stat ? stat_rd : 16'h0000;

  // self clearing reset bit: held one cycle, then applied
  assign rst_bit_d = wr_ctrl & reg_wdata[pcsmc_pkg::CB_RESET];
  assign loop_d    = wr_ctrl ? reg_wdata[pcsmc_pkg::CB_LOOP] : loop_q;
  assign an_en_d   = wr_ctrl ? reg_wdata[pcsmc_pkg::CB_AN_EN] : an_en_q;
  assign an_rst_d  = wr_ctrl ? reg_wdata[pcsmc_pkg::CB_AN_RST] : an_rst_q;
  assign unidir_d  = wr_ctrl ? reg_wdata[pcsmc_pkg::CB_UNIDIR] : unidir_q;
  assign iso_d     = wr_ctrl ? reg_wdata[pcsmc_pkg::CB_ISO] : iso_q;
  // power down: a write of one sets it, a write of zero does not clear;
  // a set written in the cycle the reset bit is held wins; a set in the same write as the reset bit is cleared
  assign pwr_d     = (wr_ctrl & reg_wdata[pcsmc_pkg::CB_PWR])
                   | (pwr_q & ~rst_bit_q);

  // link follows sync up at once, drops after the link timer
  assign lt_cnt_d  = (rx_sync | ~link_q | lt_done) ? '0 :
                     lt_cnt_q + pcsmc_pkg::LT_W'(1);
  assign link_d    = rx_sync ? 1'b1 :
                     (link_q & ~lt_done);
  // latched low bit: a read reloads, otherwise only falls
  assign latch_d   = rd_stat ? link_q : (latch_q & link_q);

  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_bit_q <= 1'b0;
      loop_q    <= pcsmc_pkg::RST_LOOP;
      an_en_q   <= pcsmc_pkg::RST_AN_EN;
      pwr_q     <= pcsmc_pkg::RST_PWR;
      iso_q     <= pcsmc_pkg::RST_ISO;
      an_rst_q  <= pcsmc_pkg::RST_AN_RST;
      unidir_q  <= pcsmc_pkg::RST_UNIDIR;
    end else begin
      rst_bit_q <= rst_bit_d;
      loop_q    <= loop_d;
      an_en_q   <= an_en_d;
      pwr_q     <= pwr_d;
      iso_q     <= iso_d;
      an_rst_q  <= an_rst_d;
      unidir_q  <= unidir_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      link_q   <= pcsmc_pkg::RST_LINK;
      latch_q  <= pcsmc_pkg::RST_LINK;
      lt_cnt_q <= '0;
    end else begin
      link_q   <= link_d;
      latch_q  <= latch_d;
      lt_cnt_q <= lt_cnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q      <= 16'h0000;
      rvalid_q     <= 1'b0;
      core_reset_q <= 1'b0;
      sl_q         <= 1'b0;
      ewrap_q      <= 1'b0;
      spd_q        <= 1'b0;
      iso_out_q    <= pcsmc_pkg::RST_ISO;
    end else begin
      rdata_q      <= rdata_d;
      rvalid_q     <= reg_rd;
      core_reset_q <= rst_bit_q;
      sl_q         <= loop_q & ~TBI_VARIANT;
      ewrap_q      <= loop_q & TBI_VARIANT;
      spd_q        <= pwr_q & ~TBI_VARIANT;
      iso_out_q    <= iso_q;
    end
  end

  assign reg_rdata         = rdata_q;
  assign reg_rvalid        = rvalid_q;
  assign core_reset        = core_reset_q;
  assign serdes_loopback   = sl_q;
  assign ewrap             = ewrap_q;
  assign serdes_power_down = spd_q;
  assign gmii_isolate      = iso_out_q;
  assign link_ok           = link_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_loop_to_serdes: assert property (
    wr_ctrl |-> ##2 serdes_loopback ==
      ($past(reg_wdata[pcsmc_pkg::CB_LOOP], 2) & ~TBI_VARIANT))
    else $error("serdes loopback does not follow written bit");

  a_loop_to_wrap: assert property (
    wr_ctrl |-> ##2 ewrap ==
      ($past(reg_wdata[pcsmc_pkg::CB_LOOP], 2) & TBI_VARIANT))
    else $error("wrap output does not follow written bit");

  a_ctrl_fixed_bits: assert property (
    rd_ctrl |=> reg_rvalid && reg_rdata[pcsmc_pkg::CB_SPD_LSB] == 1'b0
      && reg_rdata[pcsmc_pkg::CB_SPD_MSB] && reg_rdata[4:0] == 5'h00
      && reg_rdata[pcsmc_pkg::CB_DUPLEX]
      && !reg_rdata[pcsmc_pkg::CB_COLTEST])
    else $error("fixed control bits read wrong");

  a_storage_bits: assert property (
    wr_ctrl ##1 (!wr_ctrl && rd_ctrl) |=> reg_rdata[12] ==
      $past(reg_wdata[12], 2) && reg_rdata[9] == $past(reg_wdata[9], 2)
      && reg_rdata[5] == $past(reg_wdata[5], 2))
    else $error("control storage bits lost");

  a_pwr_sticky: assert property (
    pwr_q && !rst_bit_q |=> pwr_q)
    else $error("power down cleared without core reset");

  a_pwr_tbi_dead: assert property (
    TBI_VARIANT |-> !serdes_power_down)
    else $error("power down acts in ten-bit variant");

  a_iso_after_rst: assert property (
    $fell(srst) |-> gmii_isolate)
    else $error("isolate not set after reset");

  a_stat_fixed: assert property (
    rd_stat |=> reg_rdata[15:9] == 7'h00 && reg_rdata[8:5] == 4'hf
      && reg_rdata[4:3] == 2'b00 && reg_rdata[1:0] == 2'b00)
    else $error("fixed status bits read wrong");

  a_link_latch_low: assert property (
    $fell(link_q) && !$past(rd_stat) ##1 !rd_stat [*2] |=> !latch_q)
    else $error("latched link did not hold low");

  a_link_reload: assert property (
    rd_stat |=> latch_q == $past(link_q))
    else $error("status read did not reload link bit");

  a_link_needs_sync: assert property (
    rx_sync |=> link_ok)
    else $error("link not up with sync held");

  a_link_timer_drop: assert property (
    link_q && !rx_sync && !lt_done |=> link_ok)
    else $error("link dropped before link timer ran out");

  a_reset_pulse: assert property (
    wr_ctrl && reg_wdata[pcsmc_pkg::CB_RESET] |=> rst_bit_q
      ##1 core_reset && !rst_bit_q)
    else $error("core reset bit did not pulse and clear");

  a_unmapped_zero: assert property (
    reg_rd && !rd_ctrl && !rd_stat |=> reg_rdata == 16'h0000)
    else $error("unmapped address read nonzero");

  a_rvalid_after_rd: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");

  a_rvalid_idle: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data nonzero without a read");

  a_loop_hold: assert property (
    !wr_ctrl |=> $stable(loop_q))
    else $error("loopback bit changed without a write");

  a_loop_level: assert property (
    loop_q |=> serdes_loopback == !TBI_VARIANT && ewrap == TBI_VARIANT)
    else $error("loopback set but path outputs wrong");

  a_loop_off: assert property (
    !loop_q |=> !serdes_loopback && !ewrap)
    else $error("loopback clear but a path still wrapped");

  a_wrap_from_bit: assert property (
    ewrap |-> TBI_VARIANT && $past(loop_q))
    else $error("wrap output without loopback bit");

  a_ctrl_speed_msb: assert property (
    rd_ctrl |=> reg_rdata[pcsmc_pkg::CB_SPD_MSB])
    else $error("speed msb reads zero");

  a_ctrl_duplex: assert property (
    rd_ctrl |=> reg_rdata[pcsmc_pkg::CB_DUPLEX]
      && !reg_rdata[pcsmc_pkg::CB_COLTEST])
    else $error("duplex or collision test bit reads wrong");

  a_ctrl_low_zero: assert property (
    rd_ctrl |=> reg_rdata[4:0] == 5'h00)
    else $error("reserved control bits read nonzero");

  a_store_hold: assert property (
    !wr_ctrl |=> $stable(an_en_q) && $stable(an_rst_q)
      && $stable(unidir_q))
    else $error("storage bit changed without a write");

  a_iso_hold: assert property (
    !wr_ctrl |=> $stable(iso_q))
    else $error("isolate bit changed without a write");

  a_iso_to_gmii: assert property (
    wr_ctrl |-> ##2 gmii_isolate ==
      $past(reg_wdata[pcsmc_pkg::CB_ISO], 2))
    else $error("gmii isolate does not follow written bit");

  a_pwr_set: assert property (
    wr_ctrl && reg_wdata[pcsmc_pkg::CB_PWR] |=> pwr_q)
    else $error("power down write did not set the bit");

  a_pwr_to_serdes: assert property (
    pwr_q |=> serdes_power_down == !TBI_VARIANT)
    else $error("power down not passed to transceiver");

  a_pwr_rst_clear: assert property (
    rst_bit_q && !(wr_ctrl && reg_wdata[pcsmc_pkg::CB_PWR]) |=> !pwr_q)
    else $error("core reset did not clear power down");

  a_rst_bit_clear: assert property (
    rst_bit_q && !wr_ctrl |=> !rst_bit_q)
    else $error("reset bit did not clear itself");

  a_core_reset_src: assert property (
    core_reset |-> $past(rst_bit_q))
    else $error("core reset without a reset bit");

  a_link_low_nosync: assert property (
    !rx_sync && !link_q |=> !link_ok)
    else $error("link up without sync");

  a_link_timer_end: assert property (
    link_q && !rx_sync && lt_done |=> !link_ok)
    else $error("link held after link timer ran out");

  a_timer_idle: assert property (
    rx_sync |=> lt_cnt_q == '0)
    else $error("link timer runs while sync held");

  a_latch_no_rise: assert property (
    !rd_stat |=> !$rose(latch_q))
    else $error("latched link bit rose without a read");

  a_latch_follows: assert property (
    !link_q |=> !latch_q)
    else $error("latched link bit high with link down");

  a_stat_link_bit: assert property (
    rd_stat |=> reg_rdata[pcsmc_pkg::SB_LINK] == $past(latch_q))
    else $error("status read returned wrong link bit");

  a_stat_ext: assert property (
    rd_stat |=> reg_rdata[pcsmc_pkg::SB_EXT_STAT])
    else $error("extended status bit reads zero");

  a_stat_unidir: assert property (
    rd_stat |=> reg_rdata[pcsmc_pkg::SB_UNIDIR])
    else $error("unidirectional ability reads zero");

  a_stat_preamble: assert property (
    rd_stat |=> reg_rdata[pcsmc_pkg::SB_PRE_SUPP])
    else $error("preamble suppression bit reads zero");

  c_status_read: cover property (rd_stat ##1 reg_rvalid);
  c_link_drop: cover property ($fell(link_ok));
  c_core_reset: cover property ($rose(core_reset));
  c_pwr_clear: cover property (pwr_q ##1 !pwr_q);
  c_back_to_back: cover property (wr_ctrl ##1 rd_ctrl);

endmodule : pcsmc_regs

// ---- pcsmc_mgr_model.sv ----
`timescale 1ns/1ps
module pcsmc_mgr_model (
  // clock
  input  wire logic        mclk,
  // register access port
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // accesses carry no preamble and go straight to the port
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    v        = reg_rvalid;
    d        = reg_rdata;
  endtask : rd

  // write then read in the very next cycle
  task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic v);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    v         = reg_rvalid;
    q         = reg_rdata;
  endtask : wrrd
endmodule : pcsmc_mgr_model

// ---- pcs_mgmt_control_status_regs_bench.sv ----
`timescale 1ns/1ps
module pcs_mgmt_control_status_regs_bench;
  localparam int LT = 8;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        rx_sync = 1'b0;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        core_reset;
  logic        serdes_loopback;
  logic        serdes_power_down;
  logic        gmii_isolate;
  logic        link_ok;
  logic        m_ewrap;
  logic        t_ewrap;
  logic        t_loop;
  logic        t_pwr;
  logic [15:0] outs;
  logic [15:0] rdat;
  logic        rv;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          resets = 0;

  always #25 mclk = ~mclk;

  assign outs = {8'h00, link_ok, gmii_isolate, serdes_power_down,
                 serdes_loopback, m_ewrap, t_loop, t_pwr, t_ewrap};

  pcsmc_mgr_model pcsmc_mgr_model_inst (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  pcsmc_regs #(.TBI_VARIANT(1'b0), .LINK_TIMER_CYC(LT)) pcsmc_regs_inst (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rx_sync(rx_sync), .core_reset(core_reset),
    .serdes_loopback(serdes_loopback), .ewrap(m_ewrap),
    .serdes_power_down(serdes_power_down), .gmii_isolate(gmii_isolate),
    .link_ok(link_ok));

  pcsmc_regs #(.TBI_VARIANT(1'b1), .LINK_TIMER_CYC(LT)) pcsmc_regs_inst_tbi (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(),
    .reg_rvalid(), .rx_sync(rx_sync), .core_reset(),
    .serdes_loopback(t_loop), .ewrap(t_ewrap),
    .serdes_power_down(t_pwr), .gmii_isolate(), .link_ok());

  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    pcsmc_mgr_model_inst.rd(a, rdat, rv);
    check({15'h0000, rv}, 16'h0001);
    check(rdat, exp);
  endtask : rdchk

  always @(negedge mclk) begin
    if (core_reset === 1'b1) begin
      resets++;
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    #1;
    srst = 1'b0;
    check(outs, 16'h0040);
    rdchk(5'h00, 16'h1540);
    rdchk(5'h01, 16'h01e0);
    rdchk(5'h02, 16'h0000);
    rdchk(5'h1f, 16'h0000);
    pcsmc_mgr_model_inst.wr(5'h00, 16'h7fff);
    rdchk(5'h00, 16'h5f60);
    check(outs, 16'h0071);
    pcsmc_mgr_model_inst.wrrd(5'h00, 16'h0000, rdat, rv);
    check({15'h0000, rv}, 16'h0001);
    check(rdat, 16'h0940);
    check(outs, 16'h0020);
    pcsmc_mgr_model_inst.wr(5'h01, 16'hffff);
    pcsmc_mgr_model_inst.wr(5'h03, 16'hffff);
    rdchk(5'h01, 16'h01e0);
    rdchk(5'h03, 16'h0000);
    pcsmc_mgr_model_inst.wr(5'h00, 16'h8000);
    rdchk(5'h00, 16'h0140);
    check(16'(resets), 16'h0001);
    check(outs, 16'h0000);
    rx_sync = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check(outs, 16'h0080);
    rdchk(5'h01, 16'h01e0);
    rdchk(5'h01, 16'h01e4);
    rx_sync = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(outs, 16'h0080);
    repeat (LT + 1) @(posedge mclk);
    #1;
    check(outs, 16'h0000);
    rx_sync = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rdchk(5'h01, 16'h01e0);
    rdchk(5'h01, 16'h01e4);
    conclude();
  end
endmodule : pcs_mgmt_control_status_regs_bench
